// File: plc_consts.svh
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH
`define CLK_MHZ        50
`define UART_DIV16     2604
`define ZC_DIV16       2500
`define ZC_OFFSET_US   5160
`define DEAD_TIME_US   2000
`define HALF_CYCLE_US  8333
`define RESP_TO_US     100000
`define MAX_TRIES      3
`define START_BYTE     8'ha5
`define UART_BITS      4'hc
`define ZC_BITS        4'h7
`define SAMP_LO        4'h6
`define SAMP_HI        4'ha
`define START_CHK      4'h8
`define MAJORITY       3'h3
`endif

// File: plc_pkg.sv
package plc_pkg;
  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_WAIT = 2'h1, TX_SEND = 2'h3} tx_state_t;
  typedef enum logic {RX_IDLE = 1'h0, RX_BITS = 1'h1} rx_state_t;
  typedef enum logic [2:0] {
    CC_OK = 3'h0, CC_PARITY = 3'h1, CC_CSUM = 3'h2, CC_START = 3'h3, CC_COUNT = 3'h4
  } code_t;
endpackage

// File: plc_frame_codec.sv
`timescale 1ns/1ps
`include "plc_consts.svh"
// Behaviour
// [R1] start-bit unit: start, frame bit, eight data bits, parity, stop
// [R2] frame bit after start marks message start (0) or continuation (1)
// [R3] receiver ticks at sixteen times bit rate, samples mid-bit
// [R4] each bit decided by majority of five mid-bit samples
// [R5] zero-crossing transmitter silent through 2 ms around mains peaks
// [R6] zero-crossing mode sends one nibble per half-cycle, two per byte
// [R7] zero-crossing frame starts about 5.16 ms after detected crossing
// [R8] zc frame: frame bit, cycle bit, four data bits, parity, dead time
// [R9] message-start byte sends low nibble first, high nibble second
// [R10] continuation frames carry data or checksum bytes by position
// [R11] zc parity covers frame bit and that half-cycle nibble
// [R12] cycle bit tells first or second nibble of the byte
// [R13] every message carries master and slave address
// [R14] errors caught by frame parity plus whole-message checksum byte
// [R15] slave answers only if start byte was valid
// [R16] completion code zero means parity, checksum, start, count all good
// [R17] master retransmits on silence up to a limit, then aborts
// [R18] start-bit line idles high, start low, stop high
// [R19] start bit resampled half a bit later, must still be low
// [R20] stop bit gives at least one bit of high idle
// [R21] master waits a response timeout before counting a retry
// [R22] parity and checksum errors raised as status events
module plc_frame_codec
  import plc_pkg::*;
#(
  parameter int         UART_DIV16  = `UART_DIV16,
  parameter int         ZC_DIV16    = `ZC_DIV16,
  parameter int         ZC_DLY_CYC  = `ZC_OFFSET_US * `CLK_MHZ,
  parameter int         RESP_TO_CYC = `RESP_TO_US * `CLK_MHZ,
  parameter int         MAX_TRIES   = `MAX_TRIES,
  parameter logic [7:0] START_BYTE  = `START_BYTE
) (
  input  wire logic       MCLK,      // 50 MHz clock
  input  wire logic       ARST_N,    // async reset, low
  input  wire logic       ZC_MODE,   // 1 zero-crossing, 0 start-bit
  input  wire logic       IS_MASTER, // role select
  input  wire logic [7:0] MY_ADDR,   // own address
  input  wire logic [7:0] EXP_BYTES, // bytes per message incl checksum
  input  wire logic       ZC_EVENT,  // zero-crossing pulse
  input  wire logic       MODEM_RXD, // from modem data out
  output logic            MODEM_TXD, // to modem data in
  input  wire logic       TX_VALID,  // byte offered
  input  wire logic [7:0] TX_DATA,   // byte to send
  input  wire logic       TX_START,  // byte opens a message
  input  wire logic       TX_LAST,   // last byte before checksum
  output logic            TX_READY,  // byte taken when valid
  output logic            RX_VALID,  // byte received pulse
  output logic [7:0]      RX_DATA,   // received byte
  output logic            RX_START,  // byte opened a message
  output logic            PAR_ERR,   // parity error pulse
  output logic            CSUM_ERR,  // checksum error pulse
  output logic            MSG_DONE,  // message complete pulse
  output logic [2:0]      MSG_CODE,  // completion code
  output logic            ADDR_HIT,  // message was addressed to us
  output logic            RESP_REQ,  // slave should answer, pulse
  output logic            RETRY,     // master resend request pulse
  output logic            ABORT      // master gave up pulse
);
  localparam logic [15:0] UDIV = 16'(UART_DIV16 - 1);
  localparam logic [15:0] ZDIV = 16'(ZC_DIV16 - 1);
  localparam logic [23:0] ZDLY = 24'(ZC_DLY_CYC - 1);
  localparam logic [23:0] RTO  = 24'(RESP_TO_CYC - 1);
  localparam logic [2:0]  MAXT = 3'(MAX_TRIES);

  if (UART_DIV16 < 1 || UART_DIV16 > 65536 || ZC_DIV16 < 1 || ZC_DIV16 > 65536) begin : g_bad_div
    $error("sample divider out of range");
  end
  if (ZC_DLY_CYC < 1 || ZC_DLY_CYC > 16777216 || RESP_TO_CYC < 1 || RESP_TO_CYC > 16777216)
  begin : g_bad_cnt
    $error("delay count out of range");
  end
  if (MAX_TRIES < 1 || MAX_TRIES > 7) begin : g_bad_tries
    $error("retry limit out of range");
  end
  // seven-bit frame must end before the peak dead time [R5]
  if (7 * 16 * ZC_DIV16 > (`HALF_CYCLE_US - `DEAD_TIME_US) * `CLK_MHZ) begin : g_bad_zc
    $error("zero-crossing frame overruns dead time");
  end

  logic [1:0] rsy_r;
  logic       rst_n;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) rsy_r <= 2'h0;
    else rsy_r <= {rsy_r[0], 1'h1};
  end
  assign rst_n = rsy_r[1];

  logic [15:0] tk_r, tk_nxt;
  logic [23:0] zc_r, zc_nxt;
  logic        zr_r, zr_nxt, tick, zc_go;
  always_comb begin
    // >= so a mode change to a shorter divider cannot stall the tick
    tick   = tk_r >= (ZC_MODE ? ZDIV : UDIV); // [R3]
    tk_nxt = tick ? 16'h0 : tk_r + 16'h1;
    zc_go  = ZC_MODE && zr_r && (zc_r == ZDLY); // [R7]
    zr_nxt = ZC_EVENT | (zr_r & ~zc_go);
    zc_nxt = (ZC_EVENT || !zr_r) ? 24'h0 : zc_r + 24'h1;
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      tk_r <= 16'h0;
      zc_r <= 24'h0;
      zr_r <= 1'h0;
    end else begin
      tk_r <= tk_nxt;
      zc_r <= zc_nxt;
      zr_r <= zr_nxt;
    end
  end

  tx_state_t   tx_st_r, tx_st_nxt;
  logic [11:0] tsh_r, tsh_nxt;
  logic [3:0]  tn_r, tn_nxt, tph_r, tph_nxt, nib;
  logic [7:0]  tby_r, tby_nxt, tsum_r, tsum_nxt;
  logic        thalf_r, thalf_nxt, tfb_r, tfb_nxt, tck_r, tck_nxt;
  logic        tisck_r, tisck_nxt, txd_r, txd_nxt, tx_acc, tx_sent;
  assign TX_READY = (tx_st_r == TX_IDLE) && !tck_r;
  assign tx_acc   = TX_VALID && TX_READY;
  always_comb begin
    tx_st_nxt = tx_st_r;
    tsh_nxt   = tsh_r;
    tn_nxt    = tn_r;
    tph_nxt   = tph_r;
    tby_nxt   = tby_r;
    tsum_nxt  = tsum_r;
    thalf_nxt = thalf_r;
    tfb_nxt   = tfb_r;
    tck_nxt   = tck_r;
    tisck_nxt = tisck_r;
    tx_sent   = 1'h0;
    nib       = thalf_r ? tby_r[7:4] : tby_r[3:0]; // [R9]
    case (tx_st_r)
      TX_IDLE: if (tck_r || tx_acc) begin
        tby_nxt   = tck_r ? tsum_r : TX_DATA;
        tfb_nxt   = tck_r | ~TX_START; // [R2] [R10]
        tisck_nxt = tck_r;
        tck_nxt   = ~tck_r & TX_LAST;
        if (!tck_r) tsum_nxt = TX_START ? TX_DATA : tsum_r + TX_DATA; // [R14]
        thalf_nxt = 1'h0;
        tph_nxt   = 4'h0;
        if (ZC_MODE) begin
          tx_st_nxt = TX_WAIT;
        end else begin
          tx_st_nxt = TX_SEND;
          tn_nxt    = `UART_BITS;
          tsh_nxt   = {1'h1, ^{tfb_nxt, tby_nxt}, tby_nxt, tfb_nxt, 1'h0}; // [R1] [R18]
        end
      end
      TX_WAIT: if (zc_go) begin // [R7]
        tx_st_nxt = TX_SEND;
        tn_nxt    = `ZC_BITS;
        tph_nxt   = 4'h0;
        tsh_nxt   = {5'h1f, ^{tfb_r, nib}, nib, thalf_r, tfb_r}; // [R8] [R11] [R12]
      end
      TX_SEND: if (tick) begin
        tph_nxt = tph_r + 4'h1;
        if (tph_r == 4'hf) begin
          tsh_nxt = {1'h1, tsh_r[11:1]};
          tn_nxt  = tn_r - 4'h1;
          if (tn_r == 4'h1) begin
            if (ZC_MODE && !thalf_r) begin
              thalf_nxt = 1'h1; // [R6]
              tx_st_nxt = TX_WAIT;
            end else begin
              tx_st_nxt = TX_IDLE; // [R20]
              tx_sent   = tisck_r;
            end
          end
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
    // line held high outside the bit window, covering the peak dead time
    txd_nxt = (tx_st_nxt == TX_SEND) ? tsh_nxt[0] : 1'h1; // [R5] [R18]
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r <= TX_IDLE;
      tsh_r   <= 12'hfff;
      tn_r    <= 4'h0;
      tph_r   <= 4'h0;
      tby_r   <= 8'h0;
      tsum_r  <= 8'h0;
      thalf_r <= 1'h0;
      tfb_r   <= 1'h0;
      tck_r   <= 1'h0;
      tisck_r <= 1'h0;
      txd_r   <= 1'h1;
    end else begin
      tx_st_r <= tx_st_nxt;
      tsh_r   <= tsh_nxt;
      tn_r    <= tn_nxt;
      tph_r   <= tph_nxt;
      tby_r   <= tby_nxt;
      tsum_r  <= tsum_nxt;
      thalf_r <= thalf_nxt;
      tfb_r   <= tfb_nxt;
      tck_r   <= tck_nxt;
      tisck_r <= tisck_nxt;
      txd_r   <= txd_nxt;
    end
  end
  assign MODEM_TXD = txd_r;

  rx_state_t   rx_st_r, rx_st_nxt;
  logic [11:0] rsh_r, rsh_nxt, fsh;
  logic [3:0]  rph_r, rph_nxt, rn_r, rn_nxt, lo_r, lo_nxt, nb;
  logic [2:0]  ones_r, ones_nxt;
  logic [7:0]  rd_r, rd_nxt;
  logic        prev_r, rhalf_r, rhalf_nxt, lpe_r, lpe_nxt, bit_v;
  logic        rv_r, rv_nxt, rs_r, rs_nxt, pe_r, pe_nxt;
  always_comb begin
    rx_st_nxt = rx_st_r;
    rsh_nxt   = rsh_r;
    rph_nxt   = rph_r;
    rn_nxt    = rn_r;
    lo_nxt    = lo_r;
    ones_nxt  = ones_r;
    rhalf_nxt = rhalf_r;
    lpe_nxt   = lpe_r;
    rd_nxt    = rd_r;
    rs_nxt    = rs_r;
    rv_nxt    = 1'h0;
    pe_nxt    = 1'h0;
    nb        = ZC_MODE ? `ZC_BITS : `UART_BITS;
    bit_v     = ones_r >= `MAJORITY; // [R4]
    fsh       = {bit_v, rsh_r[11:1]};
    case (rx_st_r)
      RX_IDLE: if (ZC_MODE ? zc_go : (prev_r && !MODEM_RXD)) begin // [R18]
        rx_st_nxt = RX_BITS;
        rph_nxt   = 4'h0;
        ones_nxt  = 3'h0;
        rn_nxt    = 4'h0;
      end
      RX_BITS: if (tick) begin
        rph_nxt = rph_r + 4'h1;
        if (rph_r >= `SAMP_LO && rph_r <= `SAMP_HI) ones_nxt = ones_r + {2'h0, MODEM_RXD}; // [R3]
        if (!ZC_MODE && rn_r == 4'h0 && rph_r == `START_CHK && MODEM_RXD) begin
          rx_st_nxt = RX_IDLE; // [R19]
        end else if (rph_r == 4'hf) begin
          rsh_nxt  = fsh;
          ones_nxt = 3'h0;
          rn_nxt   = rn_r + 4'h1;
          if (rn_r + 4'h1 == nb) begin
            rx_st_nxt = RX_IDLE;
            if (!ZC_MODE) begin
              rv_nxt = 1'h1;
              rd_nxt = fsh[9:2]; // [R1]
              rs_nxt = ~fsh[1]; // [R2]
              pe_nxt = (^fsh[10:1]) | ~fsh[11]; // [R22]
            end else if (!fsh[6]) begin // [R12]
              lo_nxt    = fsh[10:7];
              lpe_nxt   = ^{fsh[5], fsh[10:7], fsh[11]}; // [R11]
              rhalf_nxt = 1'h1;
            end else if (rhalf_r) begin
              rhalf_nxt = 1'h0; // [R6]
              rv_nxt    = 1'h1;
              rd_nxt    = {fsh[10:7], lo_r}; // [R9]
              rs_nxt    = ~fsh[5];
              pe_nxt    = lpe_r | (^{fsh[5], fsh[10:7], fsh[11]}); // [R11] [R22]
            end
          end
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= RX_IDLE;
      rsh_r   <= 12'h0;
      rph_r   <= 4'h0;
      rn_r    <= 4'h0;
      lo_r    <= 4'h0;
      ones_r  <= 3'h0;
      prev_r  <= 1'h1;
      rhalf_r <= 1'h0;
      lpe_r   <= 1'h0;
      rd_r    <= 8'h0;
      rs_r    <= 1'h0;
      rv_r    <= 1'h0;
      pe_r    <= 1'h0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rsh_r   <= rsh_nxt;
      rph_r   <= rph_nxt;
      rn_r    <= rn_nxt;
      lo_r    <= lo_nxt;
      ones_r  <= ones_nxt;
      prev_r  <= MODEM_RXD;
      rhalf_r <= rhalf_nxt;
      lpe_r   <= lpe_nxt;
      rd_r    <= rd_nxt;
      rs_r    <= rs_nxt;
      rv_r    <= rv_nxt;
      pe_r    <= pe_nxt;
    end
  end
  assign RX_VALID = rv_r;
  assign RX_DATA  = rd_r;
  assign RX_START = rs_r;
  assign PAR_ERR  = pe_r;

  code_t      code_r, code_nxt;
  logic [7:0] idx_r, idx_nxt, msum_r, msum_nxt;
  logic       in_r, in_nxt, bad_r, bad_nxt, mpe_r, mpe_nxt, hit_r, hit_nxt;
  logic       done_r, done_nxt, ce_r, ce_nxt, rq_r, rq_nxt;
  always_comb begin
    code_nxt = code_r;
    idx_nxt  = idx_r;
    msum_nxt = msum_r;
    in_nxt   = in_r;
    bad_nxt  = bad_r;
    mpe_nxt  = mpe_r;
    hit_nxt  = hit_r;
    done_nxt = 1'h0;
    ce_nxt   = 1'h0;
    rq_nxt   = 1'h0;
    if (rv_r && rs_r) begin
      if (in_r) begin
        // a new start cuts the old message short
        done_nxt = 1'h1;
        code_nxt = CC_COUNT; // [R16]
        rq_nxt   = ~IS_MASTER & ~bad_r & hit_r; // [R15]
      end
      in_nxt   = 1'h1;
      idx_nxt  = 8'h1;
      msum_nxt = rd_r;
      bad_nxt  = rd_r != START_BYTE;
      mpe_nxt  = pe_r;
      hit_nxt  = 1'h0;
    end else if (rv_r && in_r) begin
      idx_nxt  = idx_r + 8'h1; // [R10]
      msum_nxt = msum_r + rd_r;
      mpe_nxt  = mpe_r | pe_r;
      if (idx_r == (IS_MASTER ? 8'h1 : 8'h2) && rd_r == MY_ADDR) hit_nxt = 1'h1; // [R13]
      if (idx_r + 8'h1 == EXP_BYTES) begin
        in_nxt   = 1'h0;
        done_nxt = 1'h1;
        ce_nxt   = msum_r != rd_r; // [R14] [R22]
        code_nxt = bad_r ? CC_START : (mpe_r | pe_r) ? CC_PARITY :
                   (msum_r != rd_r) ? CC_CSUM : CC_OK; // [R16]
        rq_nxt   = ~IS_MASTER & ~bad_r & hit_nxt; // [R15]
      end
    end
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      code_r <= CC_OK;
      idx_r  <= 8'h0;
      msum_r <= 8'h0;
      in_r   <= 1'h0;
      bad_r  <= 1'h0;
      mpe_r  <= 1'h0;
      hit_r  <= 1'h0;
      done_r <= 1'h0;
      ce_r   <= 1'h0;
      rq_r   <= 1'h0;
    end else begin
      code_r <= code_nxt;
      idx_r  <= idx_nxt;
      msum_r <= msum_nxt;
      in_r   <= in_nxt;
      bad_r  <= bad_nxt;
      mpe_r  <= mpe_nxt;
      hit_r  <= hit_nxt;
      done_r <= done_nxt;
      ce_r   <= ce_nxt;
      rq_r   <= rq_nxt;
    end
  end
  assign MSG_DONE = done_r;
  assign MSG_CODE = code_r;
  assign CSUM_ERR = ce_r;
  assign ADDR_HIT = hit_r;
  assign RESP_REQ = rq_r;

  logic [23:0] to_r, to_nxt;
  logic [2:0]  tr_r, tr_nxt;
  logic        mw_r, mw_nxt, rt_r, rt_nxt, ab_r, ab_nxt;
  always_comb begin
    mw_nxt = mw_r;
    tr_nxt = tr_r;
    to_nxt = mw_r ? to_r + 24'h1 : 24'h0;
    rt_nxt = 1'h0;
    ab_nxt = 1'h0;
    if (tx_sent && IS_MASTER) begin
      mw_nxt = 1'h1;
      to_nxt = 24'h0;
      tr_nxt = tr_r + 3'h1;
    end else if (mw_r && done_r) begin
      mw_nxt = 1'h0;
      tr_nxt = 3'h0;
    end else if (mw_r && to_r == RTO) begin // [R21]
      mw_nxt = 1'h0;
      if (tr_r >= MAXT) begin
        ab_nxt = 1'h1; // [R17]
        tr_nxt = 3'h0;
      end else begin
        rt_nxt = 1'h1;
      end
    end
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      to_r <= 24'h0;
      tr_r <= 3'h0;
      mw_r <= 1'h0;
      rt_r <= 1'h0;
      ab_r <= 1'h0;
    end else begin
      to_r <= to_nxt;
      tr_r <= tr_nxt;
      mw_r <= mw_nxt;
      rt_r <= rt_nxt;
      ab_r <= ab_nxt;
    end
  end
  assign RETRY = rt_r;
  assign ABORT = ab_r;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n);
  a_line_idle: assert property (tx_st_r == TX_IDLE |-> MODEM_TXD) // [R18]
    else $error("line not high while idle");
  a_start_low: assert property ($rose(tx_st_r == TX_SEND) && !ZC_MODE |-> !MODEM_TXD) // [R1]
    else $error("start bit not low");
  a_stop_high: assert property (tx_st_r == TX_SEND && !ZC_MODE && tn_r == 4'h1 |-> MODEM_TXD) // [R20]
    else $error("stop bit not high");
  a_zc_offset: assert property ($rose(tx_st_r == TX_SEND) && ZC_MODE |-> $past(zc_go)) // [R7]
    else $error("zc frame not aligned to offset");
  a_start_check: assert property (rx_st_r == RX_BITS && tick && !ZC_MODE && rn_r == 4'h0 &&
    rph_r == `START_CHK && MODEM_RXD |=> rx_st_r == RX_IDLE) // [R19]
    else $error("false start accepted");
  a_bit_vote: assert property (rx_st_r == RX_BITS && tick && rph_r == 4'hf
    |=> rsh_r[11] == ($past(ones_r) >= `MAJORITY)) // [R4]
    else $error("bit not majority of samples");
  a_resp_gate: assert property (RESP_REQ |-> MSG_DONE && MSG_CODE != CC_START && !IS_MASTER) // [R15]
    else $error("response without valid start");
  a_code_zero: assert property (MSG_DONE && MSG_CODE == CC_OK |-> !CSUM_ERR) // [R16]
    else $error("ok code with checksum error");
  a_abort_lim: assert property ($rose(ABORT) |-> $past(tr_r) == MAXT && !mw_r) // [R17]
    else $error("abort not at retry limit");
  c_rx_byte: cover property (RX_VALID && !PAR_ERR);
  c_msg_ok: cover property (MSG_DONE && MSG_CODE == CC_OK);
  c_retry: cover property (RETRY);
  c_abort: cover property (ABORT);
endmodule

// File: plc_modem_model.sv
`timescale 1ns/1ps
// far-side modem: drives the codec's serial input, samples its serial output
module plc_modem_model #(
  parameter int BIT = 32
) (
  input  wire logic clk, // codec clock
  input  wire logic txd, // codec serial out
  output logic      rxd  // codec serial in
);
  initial rxd = 1'b1;
  // one tick of each bit after the first inverted, so only the vote saves it
  task automatic send(input logic [11:0] b, input int n, input int spike);
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < BIT; k++) begin
        @(posedge clk);
        rxd <= (i > 0 && k / (BIT / 16) == spike) ? ~b[i] : b[i];
      end
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask
  // too short to survive the mid-bit recheck
  task automatic glitch(input int len);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (len) @(posedge clk);
    rxd <= 1'b1;
  endtask
  // returns at mid last bit, so a back-to-back start edge is not missed
  task automatic grab(input int n, output logic [11:0] b);
    b = 12'hfff;
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      b[i] = txd;
      if (i < n - 1) repeat (BIT) @(posedge clk);
    end
  endtask
endmodule

// File: power_line_frame_codec_bench.sv
`timescale 1ns/1ps
`include "plc_consts.svh"
module power_line_frame_codec_bench;
  import plc_pkg::*;
  logic       mclk = 1'b0, arst_n = 1'b0, zc_mode = 1'b0, is_master = 1'b0;
  logic       zc_event = 1'b0, zc_run = 1'b0, pend4 = 1'b0;
  logic       tx_valid = 1'b0, tx_start = 1'b0, tx_last = 1'b0;
  logic [7:0] my_addr = 8'h00, exp_bytes = 8'h05, tx_data = 8'h00, rx_data;
  logic       txd, rxd, tx_ready, rx_valid, rx_start, par_err, csum_err;
  logic       msg_done, addr_hit, resp_req, retry, abort;
  logic [2:0] msg_code;
  logic [9:0] rxq[$];
  logic [4:0] mq[$];
  int         fail_count = 0, n_checks = 0, cyc = 0, zcc = 0, n_retry = 0;

  plc_frame_codec #(.UART_DIV16(2), .ZC_DIV16(2), .ZC_DLY_CYC(200), .RESP_TO_CYC(2000)) DUT (
    .MCLK(mclk), .ARST_N(arst_n), .ZC_MODE(zc_mode), .IS_MASTER(is_master),
    .MY_ADDR(my_addr), .EXP_BYTES(exp_bytes), .ZC_EVENT(zc_event), .MODEM_RXD(rxd),
    .MODEM_TXD(txd), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_START(tx_start),
    .TX_LAST(tx_last), .TX_READY(tx_ready), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_START(rx_start), .PAR_ERR(par_err), .CSUM_ERR(csum_err), .MSG_DONE(msg_done),
    .MSG_CODE(msg_code), .ADDR_HIT(addr_hit), .RESP_REQ(resp_req), .RETRY(retry),
    .ABORT(abort));
  plc_modem_model modem (.clk(mclk), .txd(txd), .rxd(rxd));

  initial begin
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1) rxq.push_back({rx_start, par_err, rx_data});
    if (msg_done === 1'b1) mq.push_back({csum_err, resp_req, msg_code});
    if (retry === 1'b1) n_retry++;
    zcc <= (zc_run && zcc < 599) ? zcc + 1 : 0;
    zc_event <= zc_run && zcc == 599;
    if (cyc == 60000) begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  function automatic logic [11:0] unit(input logic fb, input logic [7:0] d, input logic bad);
    return {1'b1, ^{fb, d} ^ bad, d, fb, 1'b0};
  endfunction

  function automatic logic [11:0] zfr(input logic fb, input logic c1, input logic [3:0] n);
    return {5'h1f, ^{fb, n}, n, c1, fb};
  endfunction

  task automatic offer(input logic [7:0] d, input logic st, input logic lst);
    int n;
    n = 0;
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_data <= d;
    tx_start <= st;
    tx_last <= lst;
    do begin
      @(posedge mclk);
      n++;
    end while (tx_ready !== 1'b1 && n < 3000);
    tx_valid <= 1'b0;
  endtask

  task automatic wait_sig(input int which);
    int n;
    n = 0;
    while ((which == 0 ? txd !== 1'b0 : zc_event !== 1'b1) && n < 3000) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic tx_msg(input logic [7:0] a, input logic [7:0] b);
    logic [11:0] g;
    logic [7:0]  bs[3];
    bs = '{a, b, a + b};
    fork
      begin
        offer(a, 1'b1, 1'b0);
        offer(b, 1'b0, 1'b1);
      end
      for (int i = 0; i < 3; i++) begin
        wait_sig(0);
        modem.grab(12, g);
        chk(g, unit(i != 0, bs[i], 1'b0), "tx unit");
      end
    join
  endtask

  task automatic rx_msg(input logic [7:0] sb, sa, input int nb, bp, input logic bc,
                        input logic [4:0] ex, input logic hit);
    logic [7:0] bs[5];
    logic [4:0] d;
    bs = '{sb, my_addr, sa, 8'($urandom), 8'h00};
    bs[4] = bs[0] + bs[1] + bs[2] + bs[3] + {7'h00, bc};
    for (int i = 0; i < nb; i++) modem.send(unit(i != 0, bs[i], i == bp), 12, 8);
    repeat (40) @(posedge mclk);
    chk(12'(rxq.size()), 12'(nb), "rx count");
    for (int i = 0; i < nb && rxq.size() > 0; i++) begin
      chk({2'b00, rxq.pop_front()}, {2'b00, i == 0, i == bp, bs[i]}, "rx byte");
    end
    chk(12'(mq.size()), 12'(pend4 + (nb == 5)), "done count");
    if (pend4 && mq.size() > 0) begin
      d = mq.pop_front();
      chk({9'h0, d[2:0]}, {9'h0, CC_COUNT}, "short msg code");
    end
    if (nb == 5 && mq.size() > 0) begin
      chk({7'h0, mq.pop_front()}, {7'h0, ex}, "msg result");
      chk({11'h0, addr_hit}, {11'h0, hit}, "addressed");
    end
    pend4 = (nb < 5);
  endtask

  initial begin
    int n;
    logic [11:0] g;
    logic [7:0]  b;
    void'($urandom(75));
    my_addr <= 8'($urandom);
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({10'h0, txd, tx_ready}, 12'h3, "idle after reset");
    modem.glitch(4);
    repeat (600) @(posedge mclk);
    chk(12'(rxq.size()), 12'h0, "glitch dropped");
    tx_msg(8'($urandom), 8'($urandom));
    rx_msg(`START_BYTE, my_addr, 5, -1, 1'b0, {2'b01, CC_OK}, 1'b1);
    rx_msg(`START_BYTE, my_addr, 2, -1, 1'b0, 5'h00, 1'b0);
    rx_msg(`START_BYTE, my_addr, 5, 3, 1'b0, {2'b01, CC_PARITY}, 1'b1);
    rx_msg(`START_BYTE, my_addr, 5, -1, 1'b1, {2'b11, CC_CSUM}, 1'b1);
    rx_msg(`START_BYTE ^ 8'h01, ~my_addr, 5, -1, 1'b0, {2'b00, CC_START}, 1'b0);
    rx_msg(`START_BYTE, ~my_addr, 5, -1, 1'b0, {2'b00, CC_OK}, 1'b0);
    is_master <= 1'b1;
    tx_msg(`START_BYTE, 8'($urandom));
    rx_msg(`START_BYTE, 8'($urandom), 5, -1, 1'b0, {2'b00, CC_OK}, 1'b1);
    repeat (500) @(posedge mclk);
    chk(12'(n_retry), 12'h0, "answered, no resend");
    for (int t = 1; t <= 3; t++) begin
      tx_msg(`START_BYTE, 8'($urandom));
      n = 0;
      while (retry !== 1'b1 && abort !== 1'b1 && n < 3000) begin
        @(posedge mclk);
        n++;
      end
      chk(12'(n > 1995 && n < 2060), 12'h1, "response wait");
      chk({11'h0, abort}, 12'(t == 3), "retry or abort");
    end
    is_master <= 1'b0;
    zc_mode <= 1'b1;
    zc_run <= 1'b1;
    exp_bytes <= 8'h02;
    b = 8'($urandom);
    // offered before the first crossing, so frame 0 follows the first pulse seen below
    offer(b, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wait_sig(1);
      n = 0;
      repeat (199) begin
        @(posedge mclk);
        n += (txd === 1'b1);
      end
      chk(12'(n), 12'd199, "silent before frame");
      modem.grab(7, g);
      chk(g, zfr(i > 1, i[0], i[0] ? b[7:4] : b[3:0]), "zc frame");
    end
    for (int i = 0; i < 5; i++) begin
      wait_sig(1);
      repeat (200) @(posedge mclk);
      b = `START_BYTE;
      modem.send(zfr(i > 2, i != 1 && i != 3, i[0] ? b[3:0] : b[7:4]), 7, 99);
    end
    repeat (300) @(posedge mclk);
    chk(12'(rxq.size()), 12'h2, "zc byte count");
    for (int i = 0; i < 2 && rxq.size() > 0; i++) begin
      chk({2'b00, rxq.pop_front()}, {2'b00, i == 0, 1'b0, b}, "zc rx byte");
    end
    chk(12'(mq.size()), 12'h1, "zc done");
    if (mq.size() > 0) chk({7'h0, mq.pop_front() & 5'h07}, {9'h0, CC_OK}, "zc code");
    results();
  end
endmodule
